//--- rtl/banked_rf_pkg.sv
// constants, types and slot decoding shared by the banked register file
package banked_rf_pkg;

	// storage totals
	localparam int unsigned GP_TOTAL     = 31;
	localparam int unsigned STATUS_TOTAL = 6;
	localparam int unsigned SAVED_TOTAL  = 5;
	localparam int unsigned VISIBLE      = 16;
	localparam int unsigned SLOTS        = 30;
	localparam int unsigned SLOT_W       = 5;

	// mode field codes
	localparam logic [4:0] MODE_USER   = 5'h00;
	localparam logic [4:0] MODE_FAST   = 5'h01;
	localparam logic [4:0] MODE_IRQ    = 5'h02;
	localparam logic [4:0] MODE_SVC    = 5'h03;
	localparam logic [4:0] MODE_ABORT  = 5'h04;
	localparam logic [4:0] MODE_UNDEF  = 5'h05;
	localparam logic [4:0] MODE_SYSTEM = 5'h06;

	// register indices
	localparam logic [3:0] IDX_SHARED_HI = 4'h7;
	localparam logic [3:0] IDX_FAST_HI   = 4'hC;
	localparam logic [3:0] IDX_STACK     = 4'hD;
	localparam logic [3:0] IDX_LINK      = 4'hE;
	localparam logic [3:0] IDX_PC        = 4'hF;

	// physical slot layout
	localparam logic [4:0] SLOT_FAST_SHIFT = 5'h07;
	localparam logic [4:0] SLOT_USER_PAIR  = 5'h0D;
	localparam logic [4:0] SLOT_PAIR_BASE  = 5'h14;

	// values after reset and instruction lengths
	localparam logic [31:0] PC_RESET     = 32'h0000_0000;
	localparam logic [31:0] STATUS_RESET = 32'h0000_00C3;
	localparam logic [31:0] LEN_FULL     = 32'h0000_0004;
	localparam logic [31:0] LEN_COMPACT  = 32'h0000_0002;

	typedef enum logic [2:0] {
		bank_user, bank_fast, bank_irq, bank_svc, bank_abort, bank_undef
	} bank_t;

	typedef struct packed {
		logic [3:0]  flags;
		logic [19:0] unused;
		logic        irq_off;
		logic        fast_off;
		logic        compact;
		logic [4:0]  mode;
	} status_word_t;

	// mode code to register bank; system and unknown codes use the user bank
	function automatic bank_t mode_bank(input logic [4:0] m);
		case (m)
			MODE_FAST:  return bank_fast;
			MODE_IRQ:   return bank_irq;
			MODE_SVC:   return bank_svc;
			MODE_ABORT: return bank_abort;
			MODE_UNDEF: return bank_undef;
			default:    return bank_user;
		endcase
	endfunction : mode_bank

	function automatic logic mode_known(input logic [4:0] m);
		return (m <= MODE_SYSTEM);
	endfunction : mode_known

	// bank and index to physical slot
	function automatic logic [4:0] phys_slot(input bank_t b, input logic [3:0] idx);
		logic [4:0] base;
		base = SLOT_PAIR_BASE + {b - 3'h1, 1'b0};
		if (idx <= IDX_SHARED_HI)
			return {1'b0, idx};
		else if (idx <= IDX_FAST_HI)
			return (b == bank_fast) ? ({1'b0, idx} + SLOT_FAST_SHIFT) : {1'b0, idx};
		else if (b == bank_user)
			return SLOT_USER_PAIR + {4'h0, idx[0] ^ 1'b1};
		else
			return base + {4'h0, idx[0] ^ 1'b1};
	endfunction : phys_slot

	function automatic logic [2:0] saved_slot(input bank_t b);
		return b - 3'h1;
	endfunction : saved_slot

	function automatic logic [31:0] instr_len(input logic compact);
		return compact ? LEN_COMPACT : LEN_FULL;
	endfunction : instr_len

endpackage : banked_rf_pkg

//--- rtl/mode_banked_register_file.sv
// mode-banked register file with program counter and status words
`timescale 1ns/1ps
`default_nettype none
module mode_banked_register_file #(
	parameter int unsigned DATA_W = 32
) (
	// clock and reset
	input  wire logic                   core_clk,
	input  wire logic                   rst,

	// operand read ports, data one cycle later
	input  wire logic [3:0]             rd_a_index,
	output logic      [DATA_W-1:0]      rd_a_data,
	input  wire logic [3:0]             rd_b_index,
	output logic      [DATA_W-1:0]      rd_b_data,

	// result write port
	input  wire logic                   wr_en,
	input  wire logic [3:0]             wr_index,
	input  wire logic [DATA_W-1:0]      wr_data,

	// fetch advance and subroutine call
	input  wire logic                   fetch_en,
	input  wire logic                   call_en,
	input  wire logic [DATA_W-1:0]      call_target,

	// status word writes
	input  wire logic                   status_wr_en,
	input  wire logic                   status_wr_saved,
	input  wire logic [31:0]            status_wr_data,

	// exception entry and return
	input  wire logic                   exc_en,
	input  wire logic [4:0]             exc_mode,
	input  wire logic [DATA_W-1:0]      exc_vector,
	input  wire logic                   ret_en,
	input  wire logic [DATA_W-1:0]      ret_addr,

	// state out
	output logic      [DATA_W-1:0]      fetch_pc,
	output banked_rf_pkg::status_word_t current_status_word,
	output logic      [31:0]            saved_status_word
);

	typedef struct packed {
		logic [DATA_W-1:0] pc;
		logic [DATA_W-1:0] pc_snap;
		logic              rd_a_pc;
		logic              rd_b_pc;
	} top_state_t;

	top_state_t           state;
	top_state_t           next_state;

	banked_rf_pkg::bank_t cur_bank;
	banked_rf_pkg::bank_t exc_bank;
	logic                 exc_take;
	logic                 pc_wr;
	logic [DATA_W-1:0]    len;
	logic [DATA_W-1:0]    return_pc;

	logic                 mem_wr_en;
	logic [4:0]           mem_wr_slot;
	logic [DATA_W-1:0]    mem_wr_data;
	logic [4:0]           rd_a_slot;
	logic [4:0]           rd_b_slot;
	logic [DATA_W-1:0]    mem_a_data;
	logic [DATA_W-1:0]    mem_b_data;

	// bank of the current mode and of a requested exception mode
	assign cur_bank = banked_rf_pkg::mode_bank(current_status_word.mode);
	assign exc_bank = banked_rf_pkg::mode_bank(exc_mode);

	// only the five exception modes may be entered by exception;
	// other codes are dropped so that no saved word is overwritten
	assign exc_take = exc_en && (exc_bank != banked_rf_pkg::bank_user);

	// a result written to index fifteen is a branch
	assign pc_wr = wr_en && (wr_index == banked_rf_pkg::IDX_PC);

	// length of one instruction in the current state
	assign len = DATA_W'(banked_rf_pkg::instr_len(current_status_word.compact));

	// fetch runs two instructions ahead of execute, so the next one is one back
	assign return_pc = state.pc - len;

	// read slot decode uses the current mode only
	assign rd_a_slot = banked_rf_pkg::phys_slot(cur_bank, rd_a_index);
	assign rd_b_slot = banked_rf_pkg::phys_slot(cur_bank, rd_b_index);

	// a result that meets a call or exception in one cycle is lost
	// single write port: exception link, then call link, then result
	always_comb
	begin
		mem_wr_en   = 1'b0;
		mem_wr_slot = 5'h00;
		mem_wr_data = '0;
		if (exc_take)
		begin
			mem_wr_en   = 1'b1;
			mem_wr_slot = banked_rf_pkg::phys_slot(exc_bank, banked_rf_pkg::IDX_LINK);
			mem_wr_data = return_pc;
		end
		else if (call_en)
		begin
			mem_wr_en   = 1'b1;
			mem_wr_slot = banked_rf_pkg::phys_slot(cur_bank, banked_rf_pkg::IDX_LINK);
			mem_wr_data = return_pc;
		end
		else if (wr_en && !pc_wr)
		begin
			mem_wr_en   = 1'b1;
			mem_wr_slot = banked_rf_pkg::phys_slot(cur_bank, wr_index);
			mem_wr_data = wr_data;
		end
	end

	// program counter: exception, return, call, branch, then fetch advance
	always_comb
	begin
		next_state = state;
		if (exc_take)
			next_state.pc = exc_vector;
		else if (ret_en)
			next_state.pc = ret_addr;
		else if (call_en)
			next_state.pc = call_target;
		else if (pc_wr)
			next_state.pc = wr_data;
		else if (fetch_en)
			next_state.pc = state.pc + len;
		// reads of index fifteen return the fetch address
		next_state.pc_snap = state.pc;
		next_state.rd_a_pc = (rd_a_index == banked_rf_pkg::IDX_PC);
		next_state.rd_b_pc = (rd_b_index == banked_rf_pkg::IDX_PC);
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			state.pc      <= DATA_W'(banked_rf_pkg::PC_RESET);
			state.pc_snap <= '0;
			state.rd_a_pc <= 1'b0;
			state.rd_b_pc <= 1'b0;
		end
		else
			state <= next_state;
	end

	// thirty slots in the store plus the program counter make the general set
	reg_store #(
		.WIDTH (DATA_W),
		.DEPTH (banked_rf_pkg::SLOTS),
		.AW    (banked_rf_pkg::SLOT_W)
	) u_store (
		.core_clk  (core_clk),
		.rst       (rst),
		.wr_en     (mem_wr_en),
		.wr_slot   (mem_wr_slot),
		.wr_data   (mem_wr_data),
		.rd_a_slot (rd_a_slot),
		.rd_b_slot (rd_b_slot),
		.rd_a_data (mem_a_data),
		.rd_b_data (mem_b_data)
	);

	// current word and five saved words make the status set
	status_bank u_status (
		.core_clk            (core_clk),
		.rst                 (rst),
		.exc_take            (exc_take),
		.exc_mode            (exc_mode),
		.ret_en              (ret_en),
		.wr_en               (status_wr_en),
		.wr_to_saved         (status_wr_saved),
		.wr_data             (status_wr_data),
		.current_status_word (current_status_word),
		.saved_status_word   (saved_status_word)
	);

	// operand outputs pick the program counter or the stored word
	assign rd_a_data = state.rd_a_pc ? state.pc_snap : mem_a_data;
	assign rd_b_data = state.rd_b_pc ? state.pc_snap : mem_b_data;
	assign fetch_pc  = state.pc;

	// checks on pc movement and pc reads
	a_pc_advance: assert property (@(posedge core_clk) disable iff (rst)
		(fetch_en && !exc_take && !ret_en && !call_en && !pc_wr)
		|=> (state.pc == $past(state.pc) + $past(len)))
		else $error("fetch advance moved the pc by the wrong length");

	a_pc_operand: assert property (@(posedge core_clk) disable iff (rst)
		(rd_a_index == banked_rf_pkg::IDX_PC) |=> (rd_a_data == $past(state.pc)))
		else $error("index fifteen did not read the fetch address");

	a_pc_operand_b: assert property (@(posedge core_clk) disable iff (rst)
		(rd_b_index == banked_rf_pkg::IDX_PC)
		|=> (rd_b_data == $past(state.pc)))
		else $error("port b did not read the fetch address");

	a_branch_pc: assert property (@(posedge core_clk) disable iff (rst)
		(pc_wr && !exc_take && !ret_en && !call_en)
		|=> (state.pc == $past(wr_data)))
		else $error("branch did not load the pc");

	a_call_pc: assert property (@(posedge core_clk) disable iff (rst)
		(call_en && !exc_take && !ret_en)
		|=> (state.pc == $past(call_target)))
		else $error("call did not load its target");

	a_ret_pc: assert property (@(posedge core_clk) disable iff (rst)
		(ret_en && !exc_take)
		|=> (state.pc == $past(ret_addr)))
		else $error("return did not load its address");

	// checks on the write port
	a_call_link: assert property (@(posedge core_clk) disable iff (rst)
		(call_en && !exc_take) |-> (mem_wr_en && (mem_wr_data == state.pc - len)
			&& (mem_wr_slot
				== banked_rf_pkg::phys_slot(cur_bank, banked_rf_pkg::IDX_LINK))))
		else $error("call did not write the return address to the link");

	a_shared_low: assert property (@(posedge core_clk) disable iff (rst)
		(wr_en && (wr_index <= banked_rf_pkg::IDX_SHARED_HI) && !exc_take && !call_en)
		|-> (mem_wr_slot == {1'b0, wr_index}))
		else $error("low index write went to a banked slot");

	a_exc_link: assert property (@(posedge core_clk) disable iff (rst)
		exc_take |-> (mem_wr_en
			&& (mem_wr_slot == banked_rf_pkg::phys_slot(exc_bank, banked_rf_pkg::IDX_LINK))))
		else $error("exception entry missed the banked link");

	// checks on read slot decode and exception entry
	a_fast_bank: assert property (@(posedge core_clk) disable iff (rst)
		((cur_bank == banked_rf_pkg::bank_fast) && (rd_a_index > banked_rf_pkg::IDX_SHARED_HI)
			&& (rd_a_index <= banked_rf_pkg::IDX_FAST_HI))
		|-> (rd_a_slot == {1'b0, rd_a_index} + banked_rf_pkg::SLOT_FAST_SHIFT))
		else $error("fast mode read a base copy of a high register");

	a_private_pair: assert property (@(posedge core_clk) disable iff (rst)
		((cur_bank != banked_rf_pkg::bank_user) && (rd_a_index >= banked_rf_pkg::IDX_STACK)
			&& (rd_a_index <= banked_rf_pkg::IDX_LINK))
		|-> (rd_a_slot >= banked_rf_pkg::SLOT_PAIR_BASE))
		else $error("exception mode read a shared stack or link copy");

	a_system_user: assert property (@(posedge core_clk) disable iff (rst)
		((current_status_word.mode == banked_rf_pkg::MODE_SYSTEM)
			&& (rd_a_index != banked_rf_pkg::IDX_PC))
		|-> (rd_a_slot == {1'b0, rd_a_index}))
		else $error("system mode read a banked copy");

	a_mode_switch: assert property (@(posedge core_clk) disable iff (rst)
		exc_take |=> ((current_status_word.mode == $past(exc_mode))
			&& (state.pc == $past(exc_vector))))
		else $error("exception entry did not change mode and pc");

	a_fast_masks: assert property (@(posedge core_clk) disable iff (rst)
		(exc_take && (exc_mode == banked_rf_pkg::MODE_FAST))
		|=> (current_status_word.fast_off && current_status_word.irq_off))
		else $error("fast entry left an interrupt unmasked");

	a_exc_refused: assert property (@(posedge core_clk) disable iff (rst)
		(exc_en && !exc_take && !ret_en && !status_wr_en)
		|=> (current_status_word == $past(current_status_word)))
		else $error("refused exception changed the status word");

	// checks on slot range and bank isolation
	a_slot_range: assert property (@(posedge core_clk) disable iff (rst)
		(rd_a_slot < banked_rf_pkg::SLOTS)
		&& (rd_b_slot < banked_rf_pkg::SLOTS))
		else $error("read slot outside the store");

	a_bank_guard: assert property (@(posedge core_clk) disable iff (rst)
		(mem_wr_en && !exc_take && (cur_bank != banked_rf_pkg::bank_fast))
		|-> ((mem_wr_slot < 5'h0F) || (mem_wr_slot > 5'h15)))
		else $error("write reached a fast bank copy");

	a_shared_read: assert property (@(posedge core_clk) disable iff (rst)
		(rd_b_index <= banked_rf_pkg::IDX_SHARED_HI)
		|-> (rd_b_slot == {1'b0, rd_b_index}))
		else $error("low index read a banked copy");

endmodule : mode_banked_register_file
`default_nettype wire

//--- rtl/reg_store.sv
// word store with one write port and two registered read ports
`timescale 1ns/1ps
`default_nettype none
module reg_store #(
	parameter int unsigned WIDTH = 32,
	parameter int unsigned DEPTH = 30,
	parameter int unsigned AW    = 5
) (
	// clock and reset
	input  wire logic             core_clk,
	input  wire logic             rst,
	// write port
	input  wire logic             wr_en,
	input  wire logic [AW-1:0]    wr_slot,
	input  wire logic [WIDTH-1:0] wr_data,
	// read ports
	input  wire logic [AW-1:0]    rd_a_slot,
	input  wire logic [AW-1:0]    rd_b_slot,
	output logic      [WIDTH-1:0] rd_a_data,
	output logic      [WIDTH-1:0] rd_b_data
);
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] word;
		logic [WIDTH-1:0]            rd_a;
		logic [WIDTH-1:0]            rd_b;
	} store_state_t;

	store_state_t state;
	store_state_t next_state;

	// write first, so a read in the write cycle sees the new word
	always_comb
	begin
		next_state = state;
		if (wr_en && (wr_slot < AW'(DEPTH)))
			next_state.word[wr_slot] = wr_data;
		next_state.rd_a = next_state.word[rd_a_slot];
		next_state.rd_b = next_state.word[rd_b_slot];
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
			state <= '0;
		else
			state <= next_state;
	end

	assign rd_a_data = state.rd_a;
	assign rd_b_data = state.rd_b;

	a_read_word: assert property (@(posedge core_clk) disable iff (rst)
		(!wr_en || (wr_slot != rd_a_slot)) |=> (rd_a_data == $past(state.word[rd_a_slot])))
		else $error("read port a returned a stale word");

endmodule : reg_store
`default_nettype wire

//--- rtl/status_bank.sv
// current status word and the five saved status words
`timescale 1ns/1ps
`default_nettype none
module status_bank (
	// clock and reset
	input  wire logic                        core_clk,
	input  wire logic                        rst,
	// exception entry and return
	input  wire logic                        exc_take,
	input  wire logic [4:0]                  exc_mode,
	input  wire logic                        ret_en,
	// status writes
	input  wire logic                        wr_en,
	input  wire logic                        wr_to_saved,
	input  wire logic [31:0]                 wr_data,
	// status out
	output banked_rf_pkg::status_word_t      current_status_word,
	output logic [31:0]                      saved_status_word
);
	typedef struct packed {
		banked_rf_pkg::status_word_t current;
		logic [4:0][31:0]            saved;
	} status_state_t;

	status_state_t              state;
	status_state_t              next_state;
	banked_rf_pkg::bank_t       cur_bank;
	banked_rf_pkg::status_word_t wr_word;

	assign cur_bank = banked_rf_pkg::mode_bank(state.current.mode);
	assign wr_word  = banked_rf_pkg::status_word_t'(wr_data);

	// exception entry, then return, then software write
	always_comb
	begin
		next_state = state;
		if (exc_take)
		begin
			next_state.saved[banked_rf_pkg::saved_slot(banked_rf_pkg::mode_bank(exc_mode))]
				= state.current;
			next_state.current.mode    = exc_mode;
			next_state.current.compact = 1'b0;
			next_state.current.irq_off = 1'b1;
			if (exc_mode == banked_rf_pkg::MODE_FAST)
				next_state.current.fast_off = 1'b1;
		end
		else if (ret_en && (cur_bank != banked_rf_pkg::bank_user))
			next_state.current = state.saved[banked_rf_pkg::saved_slot(cur_bank)];
		else if (wr_en && wr_to_saved)
		begin
			if (cur_bank != banked_rf_pkg::bank_user)
				next_state.saved[banked_rf_pkg::saved_slot(cur_bank)] = wr_data;
		end
		else if (wr_en)
		begin
			next_state.current.flags = wr_word.flags;
			// user mode may change the flags only
			if (state.current.mode != banked_rf_pkg::MODE_USER)
			begin
				next_state.current.irq_off  = wr_word.irq_off;
				next_state.current.fast_off = wr_word.fast_off;
				next_state.current.compact  = wr_word.compact;
				if (banked_rf_pkg::mode_known(wr_word.mode))
					next_state.current.mode = wr_word.mode;
			end
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			state.current <= banked_rf_pkg::STATUS_RESET;
			state.saved   <= '0;
		end
		else
			state <= next_state;
	end

	assign current_status_word = state.current;
	assign saved_status_word   = (cur_bank == banked_rf_pkg::bank_user) ? 32'h0000_0000
		: state.saved[banked_rf_pkg::saved_slot(cur_bank)];

	a_exc_saves: assert property (@(posedge core_clk) disable iff (rst)
		exc_take |=> ((saved_status_word == $past(state.current))
			&& (state.current.mode == $past(exc_mode))))
		else $error("exception entry did not save the status word");

	a_user_flags: assert property (@(posedge core_clk) disable iff (rst)
		(wr_en && !wr_to_saved && !exc_take && !ret_en
			&& (state.current.mode == banked_rf_pkg::MODE_USER))
		|=> (state.current.mode == banked_rf_pkg::MODE_USER))
		else $error("user mode changed its own mode");

endmodule : status_bank
`default_nettype wire

//--- verif/pipe_model.sv
// pipeline-side model that issues reads, writes and mode changes
`timescale 1ns/1ps
`default_nettype none
module pipe_model (
	// clock and current state
	input  wire logic        core_clk,
	input  wire logic        compact,
	// requests to the register file
	output logic      [3:0]  rd_a_index,
	output logic      [3:0]  rd_b_index,
	output logic             wr_en,
	output logic      [3:0]  wr_index,
	output logic      [31:0] wr_data,
	output logic             fetch_en,
	output logic             call_en,
	output logic      [31:0] call_target,
	output logic             status_wr_en,
	output logic             status_wr_saved,
	output logic      [31:0] status_wr_data,
	output logic             exc_en,
	output logic      [4:0]  exc_mode,
	output logic      [31:0] exc_vector,
	output logic             ret_en,
	output logic      [31:0] ret_addr
);
	// quiet request lines at time zero
	initial
	begin
		{wr_en, fetch_en, call_en, status_wr_en, status_wr_saved, exc_en, ret_en} = 7'h00;
		{rd_a_index, rd_b_index, wr_index, exc_mode} = 17'h00000;
		{wr_data, call_target, status_wr_data, exc_vector, ret_addr} = 160'h0;
	end

	// targets keep word alignment in full state, halfword in compact state
	function automatic logic [31:0] aligned(input logic [31:0] a);
		return compact ? {a[31:1], 1'b0} : {a[31:2], 2'h0};
	endfunction : aligned

	// one request per edge: 1 write, 2 fetch, 3 call, 4/5 status, 6 exception, 7 return
	task automatic op(input int k, input logic [3:0] idx, input logic [31:0] d,
		input logic [4:0] m, input logic [3:0] ia, input logic [3:0] ib);
		@(posedge core_clk);
		rd_a_index      <= ia;
		rd_b_index      <= ib;
		wr_en           <= (k == 1);
		wr_index        <= idx;
		wr_data         <= d;
		fetch_en        <= (k == 2); // one fetch per instruction
		call_en         <= (k == 3);
		call_target     <= aligned(d);
		status_wr_en    <= (k == 4) || (k == 5);
		status_wr_saved <= (k == 5);
		status_wr_data  <= d;
		exc_en          <= (k == 6);
		exc_mode        <= m;
		exc_vector      <= aligned(d);
		ret_en          <= (k == 7);
		ret_addr        <= aligned(d);
	endtask : op
endmodule : pipe_model
`default_nettype wire

//--- verif/tb.sv
// self-checking bench for the mode-banked register file
`timescale 1ns/1ps
`default_nettype none
module tb;
	// request kinds of the pipeline model
	localparam int K_IDLE = 0, K_WR = 1, K_FETCH = 2, K_CALL = 3;
	localparam int K_STW = 4, K_STS = 5, K_EXC = 6, K_RET = 7;
	// note kinds: 0 port a, 1 port b, 2 pc, 3 status, 4 saved status
	typedef struct {
		int          due;
		int          kind;
		logic [31:0] val;
	} note_t;

	// clock, reset and ports
	logic                        core_clk = 1'b0;
	logic                        rst = 1'b1;
	logic [3:0]                  rd_a_index, rd_b_index, wr_index;
	logic [4:0]                  exc_mode;
	logic                        wr_en, fetch_en, call_en, status_wr_en, status_wr_saved;
	logic                        exc_en, ret_en;
	logic [31:0]                 rd_a_data, rd_b_data, wr_data, call_target, status_wr_data;
	logic [31:0]                 exc_vector, ret_addr, fetch_pc, saved_status_word;
	banked_rf_pkg::status_word_t current_status_word;
	// bench state
	note_t                       notes[$];
	note_t                       nt;
	logic [31:0]                 got, pc_exp, lnk;
	logic [31:0]                 shared[8];
	logic [4:0]                  mlist[7];
	logic [15:0]                 rnd = 16'hED2E;
	int                          cyc = 0, due = 0, err_total = 0, n_compared = 0;

	// clock and cycle count
	always #5 core_clk = ~core_clk;
	always @(posedge core_clk) cyc <= cyc + 1;

	mode_banked_register_file dut_u (
		.core_clk(core_clk), .rst(rst), .rd_a_index(rd_a_index), .rd_a_data(rd_a_data),
		.rd_b_index(rd_b_index), .rd_b_data(rd_b_data), .wr_en(wr_en), .wr_index(wr_index),
		.wr_data(wr_data), .fetch_en(fetch_en), .call_en(call_en), .call_target(call_target),
		.status_wr_en(status_wr_en), .status_wr_saved(status_wr_saved),
		.status_wr_data(status_wr_data), .exc_en(exc_en), .exc_mode(exc_mode),
		.exc_vector(exc_vector), .ret_en(ret_en), .ret_addr(ret_addr), .fetch_pc(fetch_pc),
		.current_status_word(current_status_word), .saved_status_word(saved_status_word)
	);

	pipe_model pipe_u (
		.core_clk(core_clk), .compact(current_status_word.compact), .rd_a_index(rd_a_index),
		.rd_b_index(rd_b_index), .wr_en(wr_en), .wr_index(wr_index), .wr_data(wr_data),
		.fetch_en(fetch_en), .call_en(call_en), .call_target(call_target),
		.status_wr_en(status_wr_en), .status_wr_saved(status_wr_saved),
		.status_wr_data(status_wr_data), .exc_en(exc_en), .exc_mode(exc_mode),
		.exc_vector(exc_vector), .ret_en(ret_en), .ret_addr(ret_addr)
	);

	// shift register random source
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr

	// value written to a banked index, marked with the writing mode
	function automatic logic [31:0] bval(input logic [4:0] m, input logic [3:0] i);
		return {16'hB000, 3'h0, m, 4'h0, i};
	endfunction : bval

	// last writer seen by mode m at index i; system wrote the user copies last
	function automatic logic [4:0] owner(input logic [4:0] m, input logic [3:0] i);
		if (i <= 4'hC)
			return (m == banked_rf_pkg::MODE_FAST) ? m : banked_rf_pkg::MODE_SYSTEM;
		return (m == banked_rf_pkg::MODE_USER || m == banked_rf_pkg::MODE_SYSTEM) ?
			banked_rf_pkg::MODE_SYSTEM : m;
	endfunction : owner

	task automatic next_rand(output logic [31:0] r);
		rnd = lfsr(rnd);
		r[31:16] = rnd;
		rnd = lfsr(rnd);
		r[15:0] = rnd;
	endtask : next_rand

	// issue one request; its results are due one cycle later
	task automatic go(input int k, input logic [3:0] idx, input logic [31:0] d,
		input logic [4:0] m, input logic [3:0] ia, input logic [3:0] ib);
		pipe_u.op(k, idx, d, m, ia, ib);
		due = cyc + 2;
	endtask : go

	task automatic expect_out(input int kind, input logic [31:0] v);
		notes.push_back('{due, kind, v});
	endtask : expect_out

	task automatic rd(input logic [3:0] ia, input logic [31:0] ea, input logic [3:0] ib,
		input logic [31:0] eb);
		go(K_IDLE, 4'h0, 32'h0, 5'h00, ia, ib);
		expect_out(0, ea);
		expect_out(1, eb);
	endtask : rd

	task automatic st3(input logic [31:0] pc, input logic [31:0] s, input logic [31:0] sv);
		expect_out(2, pc);
		expect_out(3, s);
		expect_out(4, sv);
	endtask : st3

	task automatic set_mode(input logic [4:0] m);
		logic [31:0] d;
		d = (m == banked_rf_pkg::MODE_USER) ? 32'h0 : {24'h0, 3'h6, m};
		go(K_STW, 4'h0, d, 5'h00, 4'h0, 4'h0);
		expect_out(3, d);
	endtask : set_mode

	task automatic report_and_stop();
		$display("compared %0d, mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : report_and_stop

	// compare each note with the output it names, in order of issue
	always @(negedge core_clk)
	begin
		while (notes.size() > 0 && notes[0].due <= cyc)
		begin
			nt = notes.pop_front();
			case (nt.kind)
				0: got = rd_a_data;
				1: got = rd_b_data;
				2: got = fetch_pc;
				3: got = current_status_word;
				default: got = saved_status_word;
			endcase
			n_compared++;
			if (nt.due != cyc || got !== nt.val)
			begin
				err_total++;
				$display("Error at %0t ns: kind %0d is %h, want %h", $time, nt.kind, got, nt.val);
			end
		end
	end

	// cut a hang short
	initial
	begin
		repeat (3000) @(posedge core_clk);
		err_total++;
		$display("Error at %0t ns: run did not finish", $time);
		report_and_stop();
	end

	// main sequence
	initial
	begin
		mlist = '{banked_rf_pkg::MODE_SVC, banked_rf_pkg::MODE_FAST, banked_rf_pkg::MODE_IRQ,
			banked_rf_pkg::MODE_ABORT, banked_rf_pkg::MODE_UNDEF, banked_rf_pkg::MODE_SYSTEM,
			banked_rf_pkg::MODE_USER};
		repeat (16) @(posedge core_clk);
		rst <= 1'b0;
		rd(4'h0, 32'h0, 4'hF, 32'h0);
		st3(32'h0, 32'h0000_00C3, 32'h0);
		for (int i = 0; i < 8; i++)
		begin
			next_rand(shared[i]);
			go(K_WR, i[3:0], shared[i], 5'h00, 4'h0, 4'h0);
		end
		go(K_STW, 4'h0, 32'h0000_00DF, 5'h00, 4'h0, 4'h0);
		expect_out(3, 32'h0000_00C3);
		$display("test reset and shared writes finished");
		for (int j = 0; j < 6; j++)
		begin
			set_mode(mlist[j]);
			for (int i = 8; i < 15; i++)
				go(K_WR, i[3:0], bval(mlist[j], i[3:0]), 5'h00, 4'h0, 4'h0);
		end
		pc_exp = 32'h0;
		for (int j = 0; j < 7; j++)
		begin
			set_mode(mlist[j]);
			for (int i = 8; i < 16; i++)
				rd(i[3:0], (i == 15) ? pc_exp : bval(owner(mlist[j], i[3:0]), i[3:0]),
					i[3:0] - 4'h8, shared[i - 8]);
		end
		$display("test banked copies finished");
		go(K_STW, 4'h0, 32'hF000_00FF, 5'h00, 4'h0, 4'h0);
		expect_out(3, 32'hF000_0000);
		for (int n = 0; n <= int'(rnd[1:0]); n++)
		begin
			pc_exp = pc_exp + 32'h4;
			go(K_FETCH, 4'h0, 32'h0, 5'h00, 4'h0, 4'h0);
			expect_out(2, pc_exp);
		end
		lnk = pc_exp - 32'h4;
		go(K_CALL, 4'h0, 32'h0000_4000, 5'h00, 4'hF, 4'h0);
		expect_out(0, pc_exp);
		expect_out(2, 32'h0000_4000);
		rd(4'hE, lnk, 4'hF, 32'h0000_4000);
		$display("test user call finished");
		go(K_EXC, 4'h0, 32'h0000_0300, banked_rf_pkg::MODE_SYSTEM, 4'h0, 4'h0);
		st3(32'h0000_4000, 32'hF000_0000, 32'h0);
		go(K_EXC, 4'h0, 32'h0000_0100, banked_rf_pkg::MODE_IRQ, 4'h0, 4'h0);
		st3(32'h0000_0100, 32'hF000_0082, 32'hF000_0000);
		rd(4'hE, 32'h0000_3FFC, 4'hD, bval(banked_rf_pkg::MODE_IRQ, 4'hD));
		go(K_STW, 4'h0, 32'hF000_00A2, 5'h00, 4'h0, 4'h0);
		expect_out(3, 32'hF000_00A2);
		go(K_FETCH, 4'h0, 32'h0, 5'h00, 4'h0, 4'h0);
		expect_out(2, 32'h0000_0102);
		go(K_STS, 4'h0, 32'h3000_0000, 5'h00, 4'h0, 4'h0);
		expect_out(4, 32'h3000_0000);
		go(K_RET, 4'h0, 32'h0000_0200, 5'h00, 4'h0, 4'h0);
		st3(32'h0000_0200, 32'h3000_0000, 32'h0);
		rd(4'hE, lnk, 4'h8, bval(banked_rf_pkg::MODE_SYSTEM, 4'h8));
		go(K_EXC, 4'h0, 32'h0000_001C, banked_rf_pkg::MODE_FAST, 4'h0, 4'h0);
		st3(32'h0000_001C, 32'h3000_00C1, 32'h3000_0000);
		rd(4'hE, 32'h0000_01FC, 4'h8, bval(banked_rf_pkg::MODE_FAST, 4'h8));
		go(K_WR, 4'hF, 32'h0000_0040, 5'h00, 4'h0, 4'h0);
		expect_out(2, 32'h0000_0040);
		$display("test exceptions and return finished");
		for (int w = 0; w < 4 && notes.size() > 0; w++)
			@(posedge core_clk);
		if (notes.size() > 0)
		begin
			err_total++;
			$display("Error at %0t ns: results still pending", $time);
		end
		report_and_stop();
	end
endmodule : tb
`default_nettype wire
